// file: core/eccp_defines.svh
// constants for the capture/compare/pwm control block
`ifndef ECCP_DEFINES_SVH
`define ECCP_DEFINES_SVH
`define ECCP_ADDR_W         4
`define ECCP_DATA_W         16
`define ECCP_ADDR_CTRL      4'h0
`define ECCP_ADDR_STAT      4'h1
`define ECCP_ADDR_MASK      4'h2
`define ECCP_ADDR_CAPT      4'h3
`define ECCP_ADDR_CMPV      4'h4
`define ECCP_CTRL_RESET     8'h00
`define ECCP_CTRL_MASK      8'hFF
`define ECCP_MODE_OFF       4'h0
`define ECCP_MODE_TOGGLE    4'h2
`define ECCP_MODE_CAP_FALL  4'h4
`define ECCP_MODE_CAP_RISE  4'h5
`define ECCP_MODE_CAP_4     4'h6
`define ECCP_MODE_CAP_16    4'h7
`define ECCP_MODE_CMP_HI    4'h8
`define ECCP_MODE_CMP_LO    4'h9
`define ECCP_MODE_CMP_SW    4'hA
`define ECCP_MODE_CMP_SPEV  4'hB
`define ECCP_PRESC_4        4'h3
`define ECCP_PRESC_16       4'hF
`define ECCP_STAT_W         2
`define ECCP_EV_FLAG        0
`define ECCP_EV_SPEV        1
`define ECCP_SEL_HI         3
`define ECCP_SEL_LO         2
`define ECCP_SEL_PWM        2'b11
`define ECCP_SEL_CAP        2'b01
`endif

// file: core/eccp_pkg.sv
// types for the capture/compare/pwm control block
`default_nettype none
package eccp_pkg;
    typedef enum logic [1:0] {
        ECCP_STEER_SINGLE,
        ECCP_STEER_FWD,
        ECCP_STEER_HALF,
        ECCP_STEER_REV
    } eccp_steer_e;
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } eccp_pins_s;
    typedef struct packed {
        eccp_steer_e pwm_output_steering;
        logic [1:0]  duty_cycle_low_bits;
        logic [3:0]  unit_mode_select;
    } eccp_ctrl_s;
    typedef struct packed {
        eccp_ctrl_s  ctrl;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [15:0] capt;
        logic [15:0] cmpv;
        logic [3:0]  presc;
        logic        pin;
        logic [2:0]  cap_sync;
        logic        cap_prev;
        logic [15:0] rdata;
    } eccp_state_s;
endpackage
`default_nettype wire

// file: core/eccp_ctrl.sv
// capture/compare/pwm control logic with register port
// ------------------------------
// Overview of operation
// ------------------------------
// Overview of operation
// RULE_01: unless both upper mode bits are one, only output a carries capture/compare and b, c, d go back to the port.
// RULE_02: full-bridge reverse modulates b, holds c active and keeps a and d inactive.
// RULE_03: mode 1010 sets the interrupt flag on a match and leaves the pin at its port state.
// RULE_04: mode 1001 drives the pin high on entry, low on a match, and sets the flag.
// RULE_05: mode 1011 makes a match only reset the timer and never starts a conversion; the code also sets status bit 1 (ECCP_EV_SPEV) on the match.
// RULE_06: capture codes take every falling, rising, fourth or sixteenth rising edge; code zero disables and resets.
`timescale 1ns/1ps
`default_nettype none
`include "eccp_defines.svh"
module eccp_ctrl (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    input  wire logic [`ECCP_ADDR_W-1:0]   addr,
    input  wire logic [`ECCP_DATA_W-1:0]   wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic      [`ECCP_DATA_W-1:0]   rdata,
    input  wire logic [15:0]               timer_value,
    input  wire logic                      pwm_wave,
    input  wire logic                      capture_pin,
    input  wire eccp_pkg::eccp_pins_s      port_value,
    output eccp_pkg::eccp_pins_s           pins_out,
    output eccp_pkg::eccp_pins_s           pins_by_unit,
    output logic                           timer_reset,
    output logic                           adc_start,
    output logic                           irq
);
    // ------------------------------
    // state
    // ------------------------------
    eccp_pkg::eccp_state_s s_q;
    eccp_pkg::eccp_state_s s_d;
    logic [3:0] mode;
    logic       match;
    logic       is_pwm;
    logic       cap_edge;
    logic       cap_rise;
    logic [1:0] ev;
    logic       entry;
    logic [3:0] pol_flip;
    eccp_pkg::eccp_pins_s pins_raw;

    assign mode   = s_q.ctrl.unit_mode_select;
    assign is_pwm = (mode[`ECCP_SEL_HI:`ECCP_SEL_LO] == `ECCP_SEL_PWM);
    assign match  = (timer_value == s_q.cmpv);

    // ------------------------------
    // capture synchroniser edges
    // ------------------------------
    assign cap_rise = s_q.cap_sync[2] & ~s_q.cap_prev & (s_q.cap_sync[2] == s_q.cap_sync[1]);
    assign cap_edge = (s_q.cap_sync[2] != s_q.cap_prev) && (s_q.cap_sync[2] == s_q.cap_sync[1]);

    // ------------------------------
    // next state
    // ------------------------------
    always_comb begin
        s_d     = s_q;
        ev      = '0;
        entry   = 1'b0;
        s_d.cap_sync = {s_q.cap_sync[1:0], capture_pin};
        if (cap_edge) begin
            s_d.cap_prev = s_q.cap_sync[2];
        end

        // ------------------------------
        // mode events
        // ------------------------------
        case (mode)
            `ECCP_MODE_CAP_FALL: begin
                if (cap_edge && !s_q.cap_sync[2]) begin
                    ev[`ECCP_EV_FLAG] = 1'b1; // RULE_06
                end
            end
            `ECCP_MODE_CAP_RISE: begin
                ev[`ECCP_EV_FLAG] = cap_rise; // RULE_06
            end
            `ECCP_MODE_CAP_4, `ECCP_MODE_CAP_16: begin
                if (cap_rise) begin
                    s_d.presc = s_q.presc + 4'h1;
                    if (s_q.presc == ((mode == `ECCP_MODE_CAP_4) ? `ECCP_PRESC_4
                                                                : `ECCP_PRESC_16)) begin
                        ev[`ECCP_EV_FLAG] = 1'b1; // RULE_06
                        s_d.presc = '0;
                    end
                end
            end
            `ECCP_MODE_TOGGLE: begin
                if (match) begin
                    s_d.pin = ~s_q.pin;
                    ev[`ECCP_EV_FLAG] = 1'b1;
                end
            end
            `ECCP_MODE_CMP_HI: begin
                if (match) begin
                    s_d.pin = 1'b1;
                    ev[`ECCP_EV_FLAG] = 1'b1;
                end
            end
            `ECCP_MODE_CMP_LO: begin
                if (match) begin
                    s_d.pin = 1'b0; // RULE_04
                    ev[`ECCP_EV_FLAG] = 1'b1; // RULE_04
                end
            end
            `ECCP_MODE_CMP_SW: begin
                ev[`ECCP_EV_FLAG] = match; // RULE_03
            end
            `ECCP_MODE_CMP_SPEV: begin
                ev[`ECCP_EV_SPEV] = match; // RULE_05
            end
            default: begin
            end
        endcase
        if (ev[`ECCP_EV_FLAG] && (mode[`ECCP_SEL_HI:`ECCP_SEL_LO] == `ECCP_SEL_CAP)) begin
            s_d.capt = timer_value; // RULE_06
        end

        // ------------------------------
        // register writes
        // ------------------------------
        if (wr) begin
            if (addr == `ECCP_ADDR_CTRL) begin
                s_d.ctrl  = eccp_pkg::eccp_ctrl_s'(wdata[7:0] & `ECCP_CTRL_MASK);
                s_d.presc = '0;
                entry     = (wdata[3:0] != mode);
                if (entry) begin
                    // compare pins take their starting level on entry
                    s_d.pin = (wdata[3:0] == `ECCP_MODE_CMP_LO); // RULE_04
                end
            end else if (addr == `ECCP_ADDR_STAT) begin
                s_d.stat = s_q.stat & ~wdata[`ECCP_STAT_W-1:0];
            end else if (addr == `ECCP_ADDR_MASK) begin
                s_d.mask = wdata[`ECCP_STAT_W-1:0];
            end else if (addr == `ECCP_ADDR_CMPV) begin
                s_d.cmpv = wdata;
            end
        end
        s_d.stat = s_d.stat | ev; // set wins over clear
        if (s_d.ctrl.unit_mode_select == `ECCP_MODE_OFF) begin
            s_d.presc = '0; // RULE_06
            s_d.pin   = 1'b0; // RULE_06
        end

        // ------------------------------
        // read data, valid one cycle after strobe
        // ------------------------------
        s_d.rdata = '0;
        if (rd) begin
            if (addr == `ECCP_ADDR_CTRL) begin
                s_d.rdata = {8'h00, s_q.ctrl};
            end else if (addr == `ECCP_ADDR_STAT) begin
                s_d.rdata = {14'h0000, s_q.stat};
            end else if (addr == `ECCP_ADDR_MASK) begin
                s_d.rdata = {14'h0000, s_q.mask};
            end else if (addr == `ECCP_ADDR_CAPT) begin
                s_d.rdata = s_q.capt;
            end else if (addr == `ECCP_ADDR_CMPV) begin
                s_d.rdata = s_q.cmpv;
            end
        end
    end

    // ------------------------------
    // registers
    // ------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------
    // outputs
    // ------------------------------
    assign rdata       = s_q.rdata;
    assign irq         = |(s_q.stat & s_q.mask);
    assign timer_reset = ev[`ECCP_EV_SPEV] & ce; // RULE_05
    assign adc_start   = 1'b0; // RULE_05

    // ------------------------------
    // pin steering
    // ------------------------------
    always_comb begin
        pins_raw     = port_value;
        pins_by_unit = '0;
        if (!is_pwm) begin
            pins_by_unit.a = (mode != `ECCP_MODE_OFF) && (mode != `ECCP_MODE_CMP_SW); // RULE_03
            if (pins_by_unit.a) begin
                pins_raw.a = s_q.pin; // RULE_01
            end
        end else begin
            pins_by_unit = '1;
            case (s_q.ctrl.pwm_output_steering)
                eccp_pkg::ECCP_STEER_SINGLE: pins_raw = '{pwm_wave, pwm_wave, pwm_wave, pwm_wave};
                eccp_pkg::ECCP_STEER_FWD:    pins_raw = '{1'b1, 1'b0, 1'b0, pwm_wave};
                eccp_pkg::ECCP_STEER_HALF: begin
                    pins_raw     = '{pwm_wave, ~pwm_wave, port_value.c, port_value.d};
                    pins_by_unit = '{1'b1, 1'b1, 1'b0, 1'b0};
                end
                default: pins_raw = '{1'b0, pwm_wave, 1'b1, 1'b0}; // RULE_02
            endcase
        end
    end

    // ------------------------------
    // output polarity
    // ------------------------------
    // low-active options: mode bit 1 on a/c, bit 0 on b/d
    for (genvar i = 0; i < $bits(eccp_pkg::eccp_pins_s); i++) begin : gen_pol
        assign pol_flip[i] = is_pwm & mode[i % 2] & pins_by_unit[i];
    end

    assign pins_out = pins_raw ^ pol_flip;
endmodule
`default_nettype wire

// file: testbench/eccp_load.sv
// load model sampling the four steered output pins
`timescale 1ns/1ps
`default_nettype none
module eccp_load (
    input  wire logic                 clk,
    input  wire eccp_pkg::eccp_pins_s pins,
    output eccp_pkg::eccp_pins_s      seen
);
    always_ff @(posedge clk) seen <= pins;
endmodule
`default_nettype wire

// file: testbench/eccp_ctrl_monitor.sv
// assertion checker for the capture/compare/pwm control block
`timescale 1ns/1ps
`default_nettype none
module eccp_ctrl_monitor (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 ce,
    input wire logic [3:0]           addr,
    input wire logic [15:0]          wdata,
    input wire logic                 wr,
    input wire logic [15:0]          timer_value,
    input wire logic                 pwm_wave,
    input wire eccp_pkg::eccp_pins_s port_value,
    input wire eccp_pkg::eccp_pins_s pins_out,
    input wire eccp_pkg::eccp_pins_s pins_by_unit,
    input wire logic                 timer_reset,
    input wire logic                 adc_start
);
    logic [3:0]  mode_q;
    logic [1:0]  steer_q;
    logic [15:0] cmp_q;
    logic        hit;
    assign hit = timer_value == cmp_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q <= 4'h0;
            steer_q <= 2'h0;
            cmp_q <= 16'h0000;
        end else if (ce && wr && addr == 4'h0) begin
            mode_q <= wdata[3:0];
            steer_q <= wdata[7:6];
        end else if (ce && wr && addr == 4'h4) begin
            cmp_q <= wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_NO_CONVERSION: assert property (!adc_start) else $error("conversion start seen");
    AST_EVENT_RESET: assert property (ce && mode_q == 4'hB && hit |-> timer_reset)
        else $error("timer reset missing");
    AST_RESET_CAUSE: assert property (timer_reset |-> mode_q == 4'hB && hit)
        else $error("timer reset without event");
    AST_PORT_RELEASE: assert property (mode_q[3:2] != 2'b11 |-> pins_by_unit[2:0] == 3'h0
        && pins_out[2:0] == port_value[2:0]) else $error("pins b c d not released");
    AST_BRIDGE_REV: assert property (mode_q == 4'hC && steer_q == 2'b11
        |-> pins_out == {1'b0, pwm_wave, 2'b10}) else $error("reverse steering wrong");
    AST_SW_PORT: assert property (mode_q == 4'hA |-> pins_out.a == port_value.a)
        else $error("pin a not at port level");
    AST_MATCH_LOW: assert property (ce && !wr && mode_q == 4'h9 && hit |=> !pins_out.a)
        else $error("pin a not forced low");
    AST_OFF_IDLE: assert property (mode_q == 4'h0 |-> pins_by_unit == 4'h0
        && pins_out == port_value) else $error("disabled unit owns pins");
    cover property (mode_q == 4'hB && timer_reset);
    cover property (mode_q == 4'h9 && hit);
    cover property (mode_q == 4'hC && steer_q == 2'b11 && pwm_wave);
endmodule
bind eccp_ctrl eccp_ctrl_monitor eccp_ctrl_monitor_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .timer_value(timer_value), .pwm_wave(pwm_wave),
    .port_value(port_value), .pins_out(pins_out), .pins_by_unit(pins_by_unit),
    .timer_reset(timer_reset), .adc_start(adc_start));
`default_nettype wire

// file: testbench/tb.sv
// testbench for the capture/compare/pwm control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, cap = 0, pwm = 0, trst, adc, irq, tr_seen;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, tmr = 16'h0000, rdata;
    eccp_pkg::eccp_pins_s pv = 4'h5, po, pu, seen;
    int          failures = 0, checks_done = 0;
    always #2 clk = ~clk;
    eccp_ctrl eccp_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .timer_value(tmr), .pwm_wave(pwm),
        .capture_pin(cap), .port_value(pv), .pins_out(po), .pins_by_unit(pu),
        .timer_reset(trst), .adc_start(adc), .irq(irq));
    eccp_load eccp_load_inst (.clk(clk), .pins(po), .seen(seen));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [15:0] e, input string n);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, e, rdata);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic hit;
        @(posedge clk);
        tmr <= 16'h0050;
        #1 tr_seen = trst;
        @(posedge clk);
        tmr <= 16'h0000;
        cyc(1);
    endtask
    task automatic pulse(input logic [15:0] t);
        @(posedge clk);
        tmr <= t;
        cap <= 1'b1;
        repeat (5) @(posedge clk);
        cap <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        int n;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rreg(i[3:0], 16'h0000, "reset");
        rreg(4'hF, 16'h0000, "unmapped");
        $display("test reset done");
        wreg(4'h0, 16'hFF30);
        rreg(4'h0, 16'h0030, "ctrl");
        wreg(4'h4, 16'h0050);
        wreg(4'h0, 16'h0009);
        cyc(2);
        chk("entry pin", 16'h1, po.a);
        chk("owner bcd", 16'h0, {pu.b, pu.c, pu.d});
        hit();
        chk("match pin", 16'h0, po.a);
        chk("irq masked", 16'h0, irq);
        rreg(4'h1, 16'h0001, "flag");
        wreg(4'h2, 16'h0003);
        cyc(1);
        chk("irq", 16'h1, irq);
        wreg(4'h1, 16'h0001);
        cyc(1);
        chk("irq clear", 16'h0, irq);
        $display("test compare low done");
        wreg(4'h0, 16'h000A);
        @(posedge clk);
        pv <= 4'h8;
        hit();
        chk("port pin", 16'h1, po.a);
        chk("no reset", 16'h0, tr_seen);
        rreg(4'h1, 16'h0001, "sw flag");
        wreg(4'h1, 16'h0003);
        wreg(4'h0, 16'h000B);
        hit();
        chk("timer reset", 16'h1, tr_seen);
        chk("no conversion", 16'h0, adc);
        rreg(4'h1, 16'h0002, "event flag");
        wreg(4'h1, 16'h0003);
        wreg(4'h0, 16'h0008);
        cyc(1);
        chk("entry low", 16'h0, po.a);
        hit();
        chk("match high", 16'h1, po.a);
        wreg(4'h0, 16'h0002);
        hit();
        chk("toggle", 16'h1, po.a);
        $display("test compare events done");
        wreg(4'h0, 16'h00CC);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            pwm <= p[0];
            cyc(2);
            chk("reverse", {12'h000, 1'b0, p[0], 2'b10}, seen);
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            pwm <= p[0];
            wreg(4'h0, 16'h004C);
            cyc(2);
            chk("forward", {12'h000, 1'b1, 2'b00, p[0]}, seen);
            wreg(4'h0, 16'h008C);
            cyc(1);
            chk("half", {12'h000, p[0], ~p[0], pv.c, pv.d}, po);
            wreg(4'h0, 16'h00CF);
            cyc(1);
            chk("polarity", {12'h000, 1'b1, ~p[0], 2'b01}, po);
        end
        wreg(4'h0, 16'h0000);
        cyc(1);
        chk("off pins", {12'h000, pv}, po);
        chk("off owner", 16'h0000, pu);
        @(posedge clk);
        ce <= 1'b0;
        wreg(4'h4, 16'h0077);
        ce <= 1'b1;
        rreg(4'h4, 16'h0050, "frozen");
        $display("test steering done");
        for (int m = 4; m < 8; m++) begin
            n = (m < 6) ? 1 : (m == 6) ? 4 : 16;
            wreg(4'h0, 16'h0000);
            wreg(4'h0, 16'(m));
            for (int e = 1; e <= n; e++) pulse(16'h1000 + 16'(e));
            rreg(4'h3, 16'h1000 + 16'(n), "capture");
        end
        $display("test capture done");
        finish_test();
    end
    initial begin
        #40000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
